/* hdl/clock_source_pkg.sv */
// Purpose: shared constants, codes and carriers of the system clock source and prescaler
// Assumes: every clock arrives as a pin level sampled by clk_sys_i
// Notes:   Function
//
// Function
// - select 11 drives system clock from direct input
// - select 10 with bypass uses output prescaler
// - prescaler input is crystal or internal source
// - division factor equals divider field plus one
// - factor one passes source through unchanged
// - largest factor is 1024
// - select 10 without bypass enables multiplier loop
// - select 00 takes wakeup clock undivided
package clock_source_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock source select codes
  localparam logic [1:0]  SEL_WAKEUP   = 2'h0;
  localparam logic [1:0]  SEL_RESERVED = 2'h1;
  localparam logic [1:0]  SEL_MULT     = 2'h2;
  localparam logic [1:0]  SEL_DIRECT   = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler sizing and reset values
  localparam int          DIV_W        = 10;
  localparam logic [10:0] FACTOR_MAX   = 11'h400;
  localparam logic [9:0]  CNT_RESET    = 10'h3ff;
  localparam logic [10:0] FACTOR_ONE   = 11'h001;
  localparam int          PIN_COUNT    = 5;
  localparam int          SYNC_STAGES  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // resolved operating mode
  typedef enum logic [2:0] {
    MODE_WAKEUP   = 3'b000,
    MODE_RESERVED = 3'b001,
    MODE_PLL      = 3'b010,
    MODE_PRESCALE = 3'b011,
    MODE_DIRECT   = 3'b100
  } mode_t;

  // raw clock pin levels
  typedef struct packed {
    logic wakeup;
    logic pll;
    logic internal;
    logic crystal;
    logic direct;
  } clk_pins_t;

  // configuration from the system clock config and multiplier config registers
  typedef struct packed {
    logic [1:0]       clock_source_select;
    logic             oscillator_bypass_bit;
    logic             prescaler_src_internal;
    logic [DIV_W-1:0] prescaler_divider_field;
  } clock_ctrl_t;

endpackage

/* hdl/pin_sync.sv */
// Purpose: two-stage synchroniser for the clock pin levels
// Assumes: pins are asynchronous to clk_sys_i
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
module pin_sync (
  input  wire logic                                  clk_sys_i,
  input  wire logic                                  rst_i,
  input  wire logic [clock_source_pkg::PIN_COUNT-1:0] pins_i,
  output logic      [clock_source_pkg::PIN_COUNT-1:0] pins_o
);

  genvar g;
  generate
    for (g = 0; g < clock_source_pkg::PIN_COUNT; g++) begin : g_bit
      logic stage1;
      logic stage2;
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= pins_i[g];
          stage2 <= stage1;
        end
      end
      assign pins_o[g] = stage2;
    end
  endgenerate

endmodule

/* hdl/system_clock_source_prescaler.sv */
// Purpose: select the system clock source and derive the prescaled clock
// Assumes: all source clocks are well below half of clk_sys_i
// Notes:   output clock is a sampled level, so edges land on clk_sys_i edges
`timescale 1ns/10ps
module system_clock_source_prescaler (
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_i,
  input  wire clock_source_pkg::clk_pins_t   clk_pins_i,
  input  wire clock_source_pkg::clock_ctrl_t ctrl_i,
  output logic                               sys_clock_o,
  output logic                               pll_enable_o,
  output clock_source_pkg::mode_t            mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  clock_source_pkg::clk_pins_t pins_s;
  logic [clock_source_pkg::PIN_COUNT-1:0] pins_s_bits;

  pin_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pins_i    (clk_pins_i),
    .pins_o    (pins_s_bits)
  );
  assign pins_s = clock_source_pkg::clk_pins_t'(pins_s_bits);

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  clock_source_pkg::mode_t next_mode;
  wire sel_mult = ctrl_i.clock_source_select == clock_source_pkg::SEL_MULT;

  assign next_mode =
    (ctrl_i.clock_source_select == clock_source_pkg::SEL_DIRECT) ? clock_source_pkg::MODE_DIRECT :
    (sel_mult && ctrl_i.oscillator_bypass_bit)                   ? clock_source_pkg::MODE_PRESCALE :
    sel_mult                                                     ? clock_source_pkg::MODE_PLL :
    (ctrl_i.clock_source_select == clock_source_pkg::SEL_WAKEUP) ? clock_source_pkg::MODE_WAKEUP :
                                                                   clock_source_pkg::MODE_RESERVED;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler
  logic [clock_source_pkg::DIV_W-1:0] cnt;
  logic [clock_source_pkg::DIV_W-1:0] div_q;
  logic                               pre_src_q;
  logic                               phase;

  wire        pre_src    = ctrl_i.prescaler_src_internal ? pins_s.internal : pins_s.crystal;
  wire        pre_rise   = pre_src && !pre_src_q;
  wire        div_change = ctrl_i.prescaler_divider_field != div_q;
  wire [10:0] factor     = {1'b0, ctrl_i.prescaler_divider_field} + clock_source_pkg::FACTOR_ONE;
  wire [10:0] high_len   = factor - {1'b0, factor[10:1]};
  wire        factor_one = factor == clock_source_pkg::FACTOR_ONE;
  wire        cnt_wrap   = cnt == ctrl_i.prescaler_divider_field;
  wire [clock_source_pkg::DIV_W-1:0] next_cnt = cnt_wrap ? '0 : cnt + 10'h001;
  wire        next_phase = {1'b0, next_cnt} < high_len;
  wire        presc_clock = factor_one ? pre_src : phase;

  // a clear restarts so that the next source edge opens a fresh output period
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt       <= clock_source_pkg::CNT_RESET;
      div_q     <= '0;
      pre_src_q <= 1'b0;
      phase     <= 1'b0;
    end else begin
      div_q     <= ctrl_i.prescaler_divider_field;
      pre_src_q <= pre_src;
      if (div_change) begin
        cnt   <= ctrl_i.prescaler_divider_field;
        phase <= 1'b0;
      end else if (pre_rise) begin
        cnt   <= next_cnt;
        phase <= next_phase;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output selection
  wire next_sys_clock =
    (next_mode == clock_source_pkg::MODE_DIRECT)   ? pins_s.direct :
    (next_mode == clock_source_pkg::MODE_PRESCALE) ? presc_clock :
    (next_mode == clock_source_pkg::MODE_PLL)      ? pins_s.pll :
    (next_mode == clock_source_pkg::MODE_WAKEUP)   ? pins_s.wakeup :
                                                     1'b0;

  // reserved select parks the clock low rather than guessing a source
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sys_clock_o  <= 1'b0;
      pll_enable_o <= 1'b0;
      mode_o       <= clock_source_pkg::MODE_WAKEUP;
    end else begin
      sys_clock_o  <= next_sys_clock;
      pll_enable_o <= next_mode == clock_source_pkg::MODE_PLL;
      mode_o       <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checker helpers: source rises and high rises seen in the current period
  // kept apart from cnt so that a broken wrap compare shows as a wrong period
  logic [10:0] rise_seen;
  logic        rise_seen_ok;
  logic [10:0] high_seen;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || div_change) begin
      rise_seen    <= 11'h000;
      rise_seen_ok <= 1'b0;
      high_seen    <= 11'h000;
    end else if (pre_rise) begin
      rise_seen    <= cnt_wrap ? 11'h001 : rise_seen + 11'h001;
      rise_seen_ok <= rise_seen_ok | cnt_wrap;
      high_seen    <= cnt_wrap ? 11'h001 : high_seen + {10'h000, next_phase};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_DIRECT_PIN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode == clock_source_pkg::MODE_DIRECT) |=> (sys_clock_o == $past(pins_s.direct)) && mode_o == clock_source_pkg::MODE_DIRECT)
    else $error("direct mode does not follow direct input");

  AST_PRESC_PATH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode == clock_source_pkg::MODE_PRESCALE && !factor_one) |=> (sys_clock_o == $past(phase)) && !pll_enable_o)
    else $error("prescale mode does not use prescaler phase");

  AST_SRC_SELECT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode == clock_source_pkg::MODE_PRESCALE && factor_one && ctrl_i.prescaler_src_internal)
      |=> sys_clock_o == $past(pins_s.internal))
    else $error("prescaler input is not the internal source");

  AST_FACTOR_WRAP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pre_rise && cnt_wrap && !div_change) |=> (cnt == '0) && phase)
    else $error("counter does not wrap at divider value");

  AST_FACTOR_ONE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode == clock_source_pkg::MODE_PRESCALE && factor_one) |=> sys_clock_o == $past(pre_src))
    else $error("factor one does not pass the source through");

  AST_LOW_HALF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pre_rise && !div_change && !factor_one && {1'b0, next_cnt} == high_len)
      |=> !phase ##1 ($stable(cnt) || $past(div_change)))
    else $error("prescaler phase not low in second part of period");

  AST_PLL_ENABLE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode == clock_source_pkg::MODE_PLL) |=> pll_enable_o && (sys_clock_o == $past(pins_s.pll)))
    else $error("multiplier mode does not enable and use the loop");

  AST_WAKEUP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode == clock_source_pkg::MODE_WAKEUP) |=> !pll_enable_o && (sys_clock_o == $past(pins_s.wakeup)))
    else $error("wakeup mode does not follow wakeup clock");

  AST_DIV_CLEAR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    div_change |=> (cnt == $past(ctrl_i.prescaler_divider_field)) && !phase)
    else $error("divider change does not restart the counter");

  AST_PERIOD_LEN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pre_rise && cnt_wrap && rise_seen_ok && !div_change)
      |-> rise_seen == factor)
    else $error("output period does not span factor source rises");

  AST_PERIOD_HIGH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pre_rise && cnt_wrap && rise_seen_ok && !div_change)
      |-> high_seen == high_len)
    else $error("output high part has the wrong number of source rises");

  AST_PERIOD_MAX: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pre_rise
      |=> rise_seen <= clock_source_pkg::FACTOR_MAX)
    else $error("output period longer than the largest factor");

  AST_FACTOR_RANGE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (factor >= clock_source_pkg::FACTOR_ONE)
      && (factor <= clock_source_pkg::FACTOR_MAX))
    else $error("division factor outside one to the largest factor");

  AST_CNT_STEP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pre_rise && !cnt_wrap && !div_change)
      |=> cnt == $past(cnt) + 10'h001)
    else $error("counter does not step on a source rise");

  AST_CNT_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!pre_rise && !div_change)
      |=> $stable(cnt) && $stable(phase))
    else $error("counter moves without a source rise");

  AST_DIRECT_NO_PLL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode == clock_source_pkg::MODE_DIRECT)
      |=> !pll_enable_o)
    else $error("direct mode enables the multiplier loop");

  AST_PRESC_MODE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode == clock_source_pkg::MODE_PRESCALE)
      |=> (mode_o == clock_source_pkg::MODE_PRESCALE) && !pll_enable_o)
    else $error("prescale select does not report prescale mode");

  AST_CRYSTAL_SRC: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode == clock_source_pkg::MODE_PRESCALE && factor_one && !ctrl_i.prescaler_src_internal)
      |=> sys_clock_o == $past(pins_s.crystal))
    else $error("prescaler input is not the crystal source");

  AST_INTERNAL_RISE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pre_rise && ctrl_i.prescaler_src_internal)
      |-> pins_s.internal)
    else $error("prescaler counts a rise the internal source did not make");

  AST_CRYSTAL_RISE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pre_rise && !ctrl_i.prescaler_src_internal)
      |-> pins_s.crystal)
    else $error("prescaler counts a rise the crystal source did not make");

  AST_PLL_OFF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode != clock_source_pkg::MODE_PLL)
      |=> !pll_enable_o)
    else $error("multiplier loop enabled outside its mode");

  AST_PLL_MODE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode == clock_source_pkg::MODE_PLL)
      |=> mode_o == clock_source_pkg::MODE_PLL)
    else $error("multiplier select does not report loop mode");

  AST_WAKEUP_MODE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (next_mode == clock_source_pkg::MODE_WAKEUP)
      |=> mode_o == clock_source_pkg::MODE_WAKEUP)
    else $error("wakeup select does not report wakeup mode");

endmodule

/* verification/system_clock_source_prescaler_tb_top.sv */
// Purpose: self-checking bench for the system clock source selector and prescaler
// Assumes: source pins toggle with an 8-cycle period, 3 high and 5 low
// Notes:   the odd duty makes pass-through visible against divided output
`timescale 1ns/10ps
module system_clock_source_prescaler_tb_top;
  logic                          clk_sys_i  = 1'b0;
  logic                          rst_i      = 1'b1;
  logic [4:0]                    pins       = 5'h00;
  clock_source_pkg::clock_ctrl_t ctrl       = '0;
  logic                          sys_clock_o;
  logic                          pll_enable_o;
  clock_source_pkg::mode_t       mode_o;
  logic                          counting   = 1'b0;
  logic                          prev_sys   = 1'b0;
  int                            rises      = 0;
  int                            highs      = 0;
  int                            num_errors = 0;
  int                            n_compared = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  system_clock_source_prescaler system_clock_source_prescaler_i (
    .clk_sys_i    (clk_sys_i),
    .rst_i        (rst_i),
    .clk_pins_i   (clock_source_pkg::clk_pins_t'(pins)),
    .ctrl_i       (ctrl),
    .sys_clock_o  (sys_clock_o),
    .pll_enable_o (pll_enable_o),
    .mode_o       (mode_o)
  );

  // output edges and high cycles of the derived clock
  always @(posedge clk_sys_i) begin
    prev_sys <= sys_clock_o;
    if (counting && sys_clock_o === 1'b1) highs <= highs + 1;
    if (counting && sys_clock_o === 1'b1 && prev_sys === 1'b0) rises <= rises + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic bad(input string msg);
    num_errors++;
    $display("BAD t=%0t %s", $time, msg);
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) bad($sformatf("bit got %b exp %b", got, exp));
  endtask
  task automatic chk_mode(input clock_source_pkg::mode_t got, input clock_source_pkg::mode_t exp);
    n_compared++;
    if (got !== exp) bad($sformatf("mode got %b exp %b", got, exp));
  endtask
  task automatic chk_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) bad($sformatf("count got %0d exp %0d", got, exp));
  endtask
  task automatic test_done;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset from an active multiplier mode with every pin high
  task automatic reset_check;
    @(negedge clk_sys_i);
    pins = 5'h1f;
    ctrl = '{2'h2, 1'b0, 1'b0, 10'h000};
    rst_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    chk_mode(mode_o, clock_source_pkg::MODE_WAKEUP);
    chk_bit(pll_enable_o, 1'b0);
    chk_bit(sys_clock_o, 1'b0);
    pins = 5'h00;
    rst_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
  endtask

  // field is flipped first under the reserved code so the prescaler restarts
  task automatic run_src(input int bi, input logic [1:0] sel, input logic byp, input logic intl,
                         input logic [9:0] field, input int nrise, input clock_source_pkg::mode_t em,
                         input int er, input int eh);
    @(negedge clk_sys_i);
    ctrl = '{2'h1, 1'b0, intl, field ^ 10'h001};
    repeat (4) @(negedge clk_sys_i);
    ctrl = '{sel, byp, intl, field};
    repeat (6) @(negedge clk_sys_i);
    chk_mode(mode_o, em);
    chk_bit(pll_enable_o, em == clock_source_pkg::MODE_PLL);
    chk_bit(sys_clock_o, 1'b0);
    rises = 0;
    highs = 0;
    counting = 1'b1;
    repeat (nrise) begin
      pins[bi] = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      pins[bi] = 1'b0;
      repeat (5) @(negedge clk_sys_i);
    end
    repeat (10) @(negedge clk_sys_i);
    counting = 1'b0;
    chk_cnt(rises, er);
    chk_cnt(highs, eh);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk_sys_i);
    rst_i = 1'b0;
    run_src(0, 2'h3, 1'b0, 1'b0, 10'h005, 5, clock_source_pkg::MODE_DIRECT, 5, 15);
    run_src(4, 2'h0, 1'b0, 1'b0, 10'h005, 4, clock_source_pkg::MODE_WAKEUP, 4, 12);
    run_src(1, 2'h1, 1'b0, 1'b0, 10'h000, 3, clock_source_pkg::MODE_RESERVED, 0, 0);
    run_src(3, 2'h2, 1'b0, 1'b0, 10'h005, 4, clock_source_pkg::MODE_PLL, 4, 12);
    reset_check();
    run_src(1, 2'h2, 1'b1, 1'b0, 10'h000, 5, clock_source_pkg::MODE_PRESCALE, 5, 15);
    run_src(2, 2'h2, 1'b1, 1'b1, 10'h001, 4, clock_source_pkg::MODE_PRESCALE, 2, 16);
    run_src(2, 2'h2, 1'b1, 1'b1, 10'h000, 3, clock_source_pkg::MODE_PRESCALE, 3, 9);
    run_src(1, 2'h2, 1'b1, 1'b0, 10'h002, 6, clock_source_pkg::MODE_PRESCALE, 2, 32);
    run_src(1, 2'h2, 1'b1, 1'b0, 10'h3ff, 2048, clock_source_pkg::MODE_PRESCALE, 2, 8192);
    test_done();
  end
endmodule
